// file: bthr_bank.v
// Hysteresis trigger bank with stack setup registers for a battery stack monitor.
// Assumes a synchronous host register port, a one-cycle sample tick and millivolt inputs.
// What this block does
// - Trip condition is input at or above level.
// - Trip only after condition holds trip delay.
// - Zero trip delay trips on first evaluation.
// - Non-latching clears after recover delay below level.
// - Zero recover delay clears immediately.
// - Hold setting selects latching or self-clearing.
// - Off setting disables trigger, never trips.
// - Latched trip stays until host clear request or off setting.
// - Self-clearing trigger clears itself after recovery.
// - Cell presence flags are only looked up by index; stack evaluation does not use them.
// - Cell index is sixteen per measurement board.
// - Thermistor presence flags are only looked up by index.
// - Thermistor index is eight per measurement board.
// - Full level versus highest cell; zero disables.
// - Average full level versus mean; zero disables.
// - Empty level versus lowest cell; zero disables.
// - Average empty level versus mean; zero disables.
// - Zero cycle life drops cycle count use.
// - Levels and inputs are in millivolts.
`timescale 1ns/1ns
`include "bthr_regs.vh"
module bthr_bank (
  // Clock, reset and enable
  input wire ref_clk,
  input wire reset,
  input wire clk_en,
  input wire sample_tick,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Monitored inputs, one 16-bit millivolt or raw value per trigger
  input wire [16*`BTHR_NUM_TRIG-1:0] trig_inputs,
  // Stack measurements in millivolts
  input wire [15:0] cell_max_mv,
  input wire [15:0] cell_min_mv,
  input wire [15:0] cell_avg_mv,
  // Cell and thermistor address lookup: measurement board and position on it
  input wire [1:0] cell_board,
  input wire [3:0] cell_pos,
  input wire [1:0] therm_board,
  input wire [2:0] therm_pos,
  // Status outputs
  output wire [`BTHR_NUM_TRIG-1:0] trig_tripped,
  output reg [`BTHR_NUM_TRIG-1:0] trig_event,
  output reg cell_index_present,
  output reg therm_index_present,
  output reg [`BTHR_NUM_CELL-1:0] cell_present,
  output reg [`BTHR_NUM_THERM-1:0] therm_present,
  output reg stack_full,
  output reg stack_empty,
  output reg cycle_count_used
);
  reg [15:0] thresh_q [0:`BTHR_NUM_TRIG-1];
  reg [15:0] trip_dly_q [0:`BTHR_NUM_TRIG-1];
  reg [15:0] recov_dly_q [0:`BTHR_NUM_TRIG-1];
  reg [1:0] ctrl_q [0:`BTHR_NUM_TRIG-1];
  reg [`BTHR_NUM_TRIG-1:0] clear_req_q;
  reg [`BTHR_NUM_TRIG-1:0] tripped_prev_q;
  reg [`BTHR_NUM_TRIG-1:0] event_sticky_q;
  reg [15:0] vfull_q;
  reg [15:0] vfullavg_q;
  reg [15:0] vempty_q;
  reg [15:0] vemptyavg_q;
  reg [15:0] cycle_life_q;
  wire trig_sel = (reg_addr[7] == 1'b0);
  wire [2:0] trig_idx = reg_addr[6:4];
  wire [1:0] trig_fld = reg_addr[3:2];
  wire [5:0] cell_index = {cell_board, cell_pos};
  wire [4:0] therm_index = {therm_board, therm_pos};
  wire [`BTHR_NUM_TRIG-1:0] changed = trig_tripped ^ tripped_prev_q;
  genvar g;
  generate
    for (g = 0; g < `BTHR_NUM_TRIG; g = g + 1) begin : gen_trig
      bthr_trigger u_trig (
        .ref_clk(ref_clk),
        .reset(reset),
        .clk_en(clk_en),
        .sample_tick(sample_tick),
        .level_in(trig_inputs[16*g +: 16]),
        .thresh(thresh_q[g]),
        .trip_dly(trip_dly_q[g]),
        .recov_dly(recov_dly_q[g]),
        .latch_en(ctrl_q[g][`BTHR_CTRL_LATCH_BIT]),
        .off(ctrl_q[g][`BTHR_CTRL_OFF_BIT]),
        .clear_req(clear_req_q[g]),
        .tripped_q(trig_tripped[g])
      );
      always @(posedge ref_clk) begin
        if (reset) begin
          thresh_q[g] <= `BTHR_RST_THRESH;
          trip_dly_q[g] <= `BTHR_RST_DLY;
          recov_dly_q[g] <= `BTHR_RST_DLY;
          ctrl_q[g] <= `BTHR_RST_CTRL;
        end else if (clk_en && reg_wr && trig_sel && trig_idx == g) begin
          case (trig_fld)
            `BTHR_OFS_THRESH: thresh_q[g] <= reg_wdata[15:0];
            `BTHR_OFS_TRIP_DLY: trip_dly_q[g] <= reg_wdata[15:0];
            `BTHR_OFS_RECOV_DLY: recov_dly_q[g] <= reg_wdata[15:0];
            default: ctrl_q[g] <= reg_wdata[1:0];
          endcase
        end
      end
    end
  endgenerate
  always @(posedge ref_clk) begin
    if (reset) begin
      clear_req_q <= {`BTHR_NUM_TRIG{1'b0}};
      tripped_prev_q <= {`BTHR_NUM_TRIG{1'b0}};
      event_sticky_q <= {`BTHR_NUM_TRIG{1'b0}};
      trig_event <= {`BTHR_NUM_TRIG{1'b0}};
      cell_present <= {`BTHR_NUM_CELL{1'b1}};
      therm_present <= `BTHR_RST_PRES;
      vfull_q <= `BTHR_RST_LEVEL;
      vfullavg_q <= `BTHR_RST_LEVEL;
      vempty_q <= `BTHR_RST_LEVEL;
      vemptyavg_q <= `BTHR_RST_LEVEL;
      cycle_life_q <= `BTHR_RST_CYCLE;
      reg_rdata <= 32'h00000000;
      cell_index_present <= 1'b0;
      therm_index_present <= 1'b0;
      stack_full <= 1'b0;
      stack_empty <= 1'b0;
      cycle_count_used <= 1'b0;
    end else if (clk_en) begin
      // Clear request is a one-cycle pulse into the trigger bank.
      clear_req_q <= (reg_wr && reg_addr == `BTHR_ADDR_CLEAR) ? reg_wdata[`BTHR_NUM_TRIG-1:0] :
                     {`BTHR_NUM_TRIG{1'b0}};
      tripped_prev_q <= trig_tripped;
      trig_event <= changed;
      // Write-one-to-clear; a new change in the same cycle wins.
      if (reg_wr && reg_addr == `BTHR_ADDR_EVENT) begin
        event_sticky_q <= (event_sticky_q & ~reg_wdata[`BTHR_NUM_TRIG-1:0]) | changed;
      end else begin
        event_sticky_q <= event_sticky_q | changed;
      end
      if (reg_wr) begin
        case (reg_addr)
          `BTHR_ADDR_CELL_PRES0: cell_present[31:0] <= reg_wdata;
          `BTHR_ADDR_CELL_PRES0 + 8'h04: cell_present[63:32] <= reg_wdata;
          `BTHR_ADDR_THERM_PRES: therm_present <= reg_wdata;
          `BTHR_ADDR_VFULL: vfull_q <= reg_wdata[15:0];
          `BTHR_ADDR_VFULLAVG: vfullavg_q <= reg_wdata[15:0];
          `BTHR_ADDR_VEMPTY: vempty_q <= reg_wdata[15:0];
          `BTHR_ADDR_VEMPTYAVG: vemptyavg_q <= reg_wdata[15:0];
          `BTHR_ADDR_CYCLE_LIFE: cycle_life_q <= reg_wdata[15:0];
          default: ;
        endcase
      end
      cell_index_present <= cell_present[cell_index];
      therm_index_present <= therm_present[therm_index];
      stack_full <= ((vfull_q != 16'h0000) && (cell_max_mv >= vfull_q)) ||
                    ((vfullavg_q != 16'h0000) && (cell_avg_mv >= vfullavg_q));
      stack_empty <= ((vempty_q != 16'h0000) && (cell_min_mv <= vempty_q)) ||
                     ((vemptyavg_q != 16'h0000) && (cell_avg_mv <= vemptyavg_q));
      cycle_count_used <= (cycle_life_q != 16'h0000);
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        if (trig_sel) begin
          case (trig_fld)
            `BTHR_OFS_THRESH: reg_rdata <= {16'h0000, thresh_q[trig_idx]};
            `BTHR_OFS_TRIP_DLY: reg_rdata <= {16'h0000, trip_dly_q[trig_idx]};
            `BTHR_OFS_RECOV_DLY: reg_rdata <= {16'h0000, recov_dly_q[trig_idx]};
            default: reg_rdata <= {30'h00000000, ctrl_q[trig_idx]};
          endcase
        end else begin
          case (reg_addr)
            `BTHR_ADDR_STATUS: reg_rdata <= {24'h000000, trig_tripped};
            `BTHR_ADDR_EVENT: reg_rdata <= {24'h000000, event_sticky_q};
            `BTHR_ADDR_CELL_PRES0: reg_rdata <= cell_present[31:0];
            `BTHR_ADDR_CELL_PRES0 + 8'h04: reg_rdata <= cell_present[63:32];
            `BTHR_ADDR_THERM_PRES: reg_rdata <= therm_present;
            `BTHR_ADDR_VFULL: reg_rdata <= {16'h0000, vfull_q};
            `BTHR_ADDR_VFULLAVG: reg_rdata <= {16'h0000, vfullavg_q};
            `BTHR_ADDR_VEMPTY: reg_rdata <= {16'h0000, vempty_q};
            `BTHR_ADDR_VEMPTYAVG: reg_rdata <= {16'h0000, vemptyavg_q};
            `BTHR_ADDR_CYCLE_LIFE: reg_rdata <= {16'h0000, cycle_life_q};
            `BTHR_ADDR_SOC_STATUS: reg_rdata <= {29'h00000000, cycle_count_used, stack_empty, stack_full};
            default: reg_rdata <= 32'h00000000;
          endcase
        end
      end
    end
  end
endmodule // bthr_bank

// file: bthr_regs.vh
// Constants for the battery threshold trigger bank: register offsets, field positions, reset values.
// Assumes inclusion by bare name from the design files.
`ifndef BTHR_REGS_VH
`define BTHR_REGS_VH
`define BTHR_NUM_TRIG 8
`define BTHR_NUM_CELL 64
`define BTHR_NUM_THERM 32
`define BTHR_CELLS_PER_BOARD 16
`define BTHR_THERMS_PER_BOARD 8
`define BTHR_NUM_BOARD 4
// Register offsets, byte addresses of 32-bit words.
`define BTHR_ADDR_TRIG_BASE 8'h00
`define BTHR_ADDR_TRIG_STRIDE 8'h10
`define BTHR_OFS_THRESH 2'h0
`define BTHR_OFS_TRIP_DLY 2'h1
`define BTHR_OFS_RECOV_DLY 2'h2
`define BTHR_OFS_CTRL 2'h3
`define BTHR_ADDR_STATUS 8'h80
`define BTHR_ADDR_CLEAR 8'h84
`define BTHR_ADDR_EVENT 8'h88
`define BTHR_ADDR_CELL_PRES0 8'h90
`define BTHR_ADDR_THERM_PRES 8'h98
`define BTHR_ADDR_VFULL 8'hA0
`define BTHR_ADDR_VFULLAVG 8'hA4
`define BTHR_ADDR_VEMPTY 8'hA8
`define BTHR_ADDR_VEMPTYAVG 8'hAC
`define BTHR_ADDR_CYCLE_LIFE 8'hB0
`define BTHR_ADDR_SOC_STATUS 8'hB4
// Control register fields.
`define BTHR_CTRL_LATCH_BIT 0
`define BTHR_CTRL_OFF_BIT 1
// Reset values.
`define BTHR_RST_THRESH 16'hFFFF
`define BTHR_RST_DLY 16'h0000
`define BTHR_RST_CTRL 2'h2
`define BTHR_RST_LEVEL 16'h0000
`define BTHR_RST_CYCLE 16'h0000
`define BTHR_RST_PRES 32'hFFFFFFFF
`endif

// file: bthr_trigger.v
// One hysteresis trigger with one counter shared by trip and recover delays, in sample-tick units.
// Assumes inputs synchronous to ref_clk and a one-cycle sample tick.
`timescale 1ns/1ns
`include "bthr_regs.vh"
module bthr_trigger (
  // Clock and reset
  input wire ref_clk,
  input wire reset,
  input wire clk_en,
  input wire sample_tick,
  // Configuration
  input wire [15:0] level_in,
  input wire [15:0] thresh,
  input wire [15:0] trip_dly,
  input wire [15:0] recov_dly,
  input wire latch_en,
  input wire off,
  input wire clear_req,
  // Status
  output reg tripped_q
);
  reg [15:0] cnt_q;
  reg [15:0] cnt_d;
  reg tripped_d;
  wire above = (level_in >= thresh);
  always @* begin
    cnt_d = cnt_q;
    tripped_d = tripped_q;
    if (off) begin
      cnt_d = 16'h0000;
      tripped_d = 1'b0;
    end else begin
      if (sample_tick) begin
        if (!tripped_q) begin
          if (!above) begin
            cnt_d = 16'h0000;
          end else if (cnt_q >= trip_dly) begin
            tripped_d = 1'b1;
            cnt_d = 16'h0000;
          end else begin
            cnt_d = cnt_q + 16'h0001;
            if (cnt_d >= trip_dly) begin
              tripped_d = 1'b1;
              cnt_d = 16'h0000;
            end
          end
        end else if (!latch_en) begin
          if (above) begin
            cnt_d = 16'h0000;
          end else if (cnt_q >= recov_dly) begin
            tripped_d = 1'b0;
            cnt_d = 16'h0000;
          end else begin
            cnt_d = cnt_q + 16'h0001;
            if (cnt_d >= recov_dly) begin
              tripped_d = 1'b0;
              cnt_d = 16'h0000;
            end
          end
        end
      end
      // Clear request only acts on a latched trip; an instant re-trip on the same tick wins over the clear.
      if (clear_req && latch_en && tripped_q) begin
        tripped_d = sample_tick && above && (trip_dly <= 16'h0001);
        cnt_d = 16'h0000;
      end
    end
  end
  always @(posedge ref_clk) begin
    if (reset) begin
      cnt_q <= 16'h0000;
      tripped_q <= 1'b0;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
      tripped_q <= tripped_d;
    end
  end
endmodule // bthr_trigger

// file: bthr_host.sv
// Host model driving the register port and issuing clear requests.
// Assumes tasks are called between rising edges of ref_clk.
`timescale 1ns/1ns
module bthr_host (
  // Clock
  input wire ref_clk,
  // Register port
  output reg [7:0] reg_addr,
  output reg [31:0] reg_wdata,
  output reg reg_wr,
  output reg reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
  end
  // Released lines show the inverse of the last value so stale data is never seen as valid.
  task wr(input [7:0] a, input [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge ref_clk);
    reg_wr <= 1'h0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task rd(input [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge ref_clk);
    reg_rd <= 1'h0;
    reg_addr <= ~a;
  endtask
  task clr(input [7:0] m);
    wr(8'h84, {24'h0, m});
  endtask
endmodule // bthr_host

// file: bthr_bank_monitor.sv
// Checker for the trigger bank top ports.
// Assumes binding to bthr_bank, one clock, synchronous reset.
`timescale 1ns/1ns
module bthr_bank_monitor (
  // Clock and reset
  input wire ref_clk,
  input wire reset,
  input wire clk_en,
  input wire sample_tick,
  // Register port
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // Status
  input wire [7:0] trig_tripped,
  input wire [7:0] trig_event,
  input wire [1:0] cell_board,
  input wire [3:0] cell_pos,
  input wire cell_index_present,
  input wire [63:0] cell_present,
  input wire stack_full,
  input wire stack_empty,
  input wire cycle_count_used
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_rise;
    |(trig_tripped & ~$past(trig_tripped)) |-> $past(sample_tick);
  endproperty
  a_rise: assert property (p_rise) else $error("trip outside a tick");
  property p_fall;
    |(~trig_tripped & $past(trig_tripped)) |-> $past(sample_tick) || $past(reg_wr) || $past(reg_wr, 2);
  endproperty
  a_fall: assert property (p_fall) else $error("clear without cause");
  property p_event;
    $past(clk_en) && $past(clk_en, 2) |-> trig_event == ($past(trig_tripped) ^ $past(trig_tripped, 2));
  endproperty
  a_event: assert property (p_event) else $error("event mismatch");
  property p_idle;
    $past(clk_en) && !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("read data outside answer cycle");
  property p_stat;
    $past(clk_en && reg_rd && reg_addr == 8'h80) |-> reg_rdata == {24'h0, $past(trig_tripped)};
  endproperty
  a_stat: assert property (p_stat) else $error("status read wrong");
  property p_soc;
    $past(clk_en && reg_rd && reg_addr == 8'hB4) |->
      reg_rdata == {29'h0, $past(cycle_count_used), $past(stack_empty), $past(stack_full)};
  endproperty
  a_soc: assert property (p_soc) else $error("charge status read wrong");
  property p_cidx;
    !$past(reset) && $past(clk_en) |-> cell_index_present == $past(cell_present[{cell_board, cell_pos}]);
  endproperty
  a_cidx: assert property (p_cidx) else $error("cell lookup wrong");
  property p_cpres;
    $past(clk_en && reg_rd && reg_addr == 8'h90) |-> reg_rdata == $past(cell_present[31:0]);
  endproperty
  a_cpres: assert property (p_cpres) else $error("cell flags read wrong");
endmodule // bthr_bank_monitor
bind bthr_bank bthr_bank_monitor i_mon (.ref_clk, .reset, .clk_en, .sample_tick, .reg_addr, .reg_wr, .reg_rd,
  .reg_rdata, .trig_tripped, .trig_event, .cell_board, .cell_pos, .cell_index_present, .cell_present,
  .stack_full, .stack_empty, .cycle_count_used);

// file: tb_bthr_bank.sv
// Self-checking bench: host model drives registers, a watcher compares read data.
// Assumes bthr_host and the bound checker are compiled first.
`timescale 1ns/1ns
module tb_bthr_bank;
  reg ref_clk = 1'h0;
  reg reset = 1'h1;
  reg sample_tick = 1'h0;
  reg en = 1'h1;
  wire [63:0] cpres;
  wire [31:0] tpres;
  reg [127:0] trig_inputs = 128'h0;
  reg [15:0] mx = 16'h0FA0;
  reg [15:0] mn = 16'h0BB8;
  reg [15:0] av = 16'h0DAC;
  reg [1:0] cb = 2'h0;
  reg [3:0] cp = 4'h0;
  reg [1:0] tb_ = 2'h0;
  reg [2:0] tp = 3'h0;
  wire [7:0] reg_addr;
  wire [31:0] reg_wdata;
  wire reg_wr;
  wire reg_rd;
  wire [31:0] reg_rdata;
  wire cip;
  wire tip;
  reg rd_d = 1'h0;
  reg [31:0] exp_q[$];
  integer fail_count = 0;
  integer n_tests = 0;
  integer cyc = 0;
  integer seed = 98629;
  always #25 ref_clk = ~ref_clk;
  bthr_host i_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd));
  bthr_bank i_dut (.ref_clk(ref_clk), .reset(reset), .clk_en(en), .sample_tick(sample_tick),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trig_inputs(trig_inputs), .cell_max_mv(mx), .cell_min_mv(mn), .cell_avg_mv(av),
    .cell_board(cb), .cell_pos(cp), .therm_board(tb_), .therm_pos(tp), .trig_tripped(), .trig_event(),
    .cell_index_present(cip), .therm_index_present(tip), .cell_present(cpres), .therm_present(tpres),
    .stack_full(), .stack_empty(), .cycle_count_used());
  task check(input [31:0] seen, input [31:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    // An expectation still queued means a read answer was never seen.
    if (exp_q.size() != 0) fail_count = fail_count + 1;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task rd(input [7:0] a, input [31:0] e);
    exp_q.push_back(e);
    i_host.rd(a);
  endtask
  task cfg(input [2:0] g, input [15:0] th, input [15:0] td, input [15:0] rc, input [1:0] ct);
    i_host.wr({1'h0, g, 4'h0}, {16'h0, th});
    i_host.wr({1'h0, g, 4'h4}, {16'h0, td});
    i_host.wr({1'h0, g, 4'h8}, {16'h0, rc});
    i_host.wr({1'h0, g, 4'hC}, {30'h0, ct});
  endtask
  task tick(input integer n);
    repeat (n) begin
      @(posedge ref_clk);
      sample_tick <= 1'h1;
      @(posedge ref_clk);
      sample_tick <= 1'h0;
    end
  endtask
  task inp(input integer g, input [15:0] v);
    trig_inputs[16*g +: 16] <= v;
  endtask
  // The answer stands only in the cycle after the strobe, so it is sampled at that falling edge.
  always @(posedge ref_clk) rd_d <= reg_rd;
  always @(negedge ref_clk) if (rd_d === 1'h1) check(reg_rdata, exp_q.pop_front());
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      fail_count = fail_count + 1;
      results();
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    reset <= 1'h0;
    rd(8'h80, 32'h0);
    rd(8'h0C, 32'h2);
    rd(8'h00, 32'hFFFF);
    rd(8'h90, 32'hFFFFFFFF);
    rd(8'hFC, 32'h0);
    cfg(3'h0, 16'd1000, 16'h3, 16'h2, 2'h0);
    inp(0, 16'd1000 + ($random(seed) & 16'hFF));
    tick(2);
    inp(0, 16'd999);
    tick(1);
    inp(0, 16'd1000 + ($random(seed) & 16'hFF));
    tick(2);
    rd(8'h80, 32'h0);
    tick(1);
    rd(8'h80, 32'h1);
    inp(0, 16'd500);
    tick(1);
    rd(8'h80, 32'h1);
    tick(1);
    rd(8'h80, 32'h0);
    cfg(3'h1, 16'd2000, 16'h0, 16'h0, 2'h1);
    inp(1, 16'd1999);
    tick(1);
    rd(8'h80, 32'h0);
    inp(1, 16'd2000);
    tick(1);
    rd(8'h80, 32'h2);
    inp(1, 16'h0);
    tick(2);
    rd(8'h80, 32'h2);
    i_host.clr(8'h02);
    rd(8'h80, 32'h0);
    cfg(3'h2, 16'd300, 16'h0, 16'h0, 2'h0);
    inp(2, 16'd300);
    tick(1);
    rd(8'h80, 32'h4);
    inp(2, 16'd299);
    tick(1);
    rd(8'h80, 32'h0);
    inp(2, 16'd300);
    tick(1);
    i_host.wr(8'h2C, 32'h2);
    tick(1);
    rd(8'h80, 32'h0);
    rd(8'h88, 32'h7);
    i_host.wr(8'h88, 32'h7);
    rd(8'h88, 32'h0);
    i_host.wr(8'hA0, 32'd4000);
    rd(8'hB4, 32'h1);
    mx <= 16'd3999;
    rd(8'hB4, 32'h0);
    i_host.wr(8'hA0, 32'h0);
    i_host.wr(8'hA4, 32'd3500);
    rd(8'hB4, 32'h1);
    i_host.wr(8'hA4, 32'h0);
    i_host.wr(8'hA8, 32'd3000);
    rd(8'hB4, 32'h2);
    i_host.wr(8'hA8, 32'h0);
    i_host.wr(8'hAC, 32'd3500);
    rd(8'hB4, 32'h2);
    i_host.wr(8'hAC, 32'h0);
    i_host.wr(8'hB0, 32'd500);
    rd(8'hB4, 32'h4);
    i_host.wr(8'hB0, 32'h0);
    rd(8'hB4, 32'h0);
    i_host.wr(8'h90, 32'hFFFEFFFF);
    i_host.wr(8'h98, 32'hFFFFFEFF);
    rd(8'h98, 32'hFFFFFEFF);
    cb <= 2'h1;
    tb_ <= 2'h1;
    repeat (3) @(negedge ref_clk);
    check(tpres, 32'hFFFFFEFF);
    check(cpres[31:0], 32'hFFFEFFFF);
    check(cpres[63:32], 32'hFFFFFFFF);
    check({31'h0, cip}, 32'h0);
    check({31'h0, tip}, 32'h0);
    cp <= 4'h1;
    tp <= 3'h1;
    repeat (3) @(negedge ref_clk);
    check({31'h0, cip}, 32'h1);
    check({31'h0, tip}, 32'h1);
    // A tick that arrives while the clock enable is low must leave the trigger untouched.
    @(posedge ref_clk);
    en <= 1'h0;
    inp(1, 16'd2000);
    tick(1);
    en <= 1'h1;
    rd(8'h80, 32'h0);
    tick(1);
    rd(8'h80, 32'h2);
    repeat (2) @(negedge ref_clk);
    results();
  end
endmodule // tb_bthr_bank
